// *** hw/epi_core.sv ***
/*
  External pin interrupt block: one request pin, polarity and mode control,
  sticky event flag with write-one acknowledge, pull device control, and an
  Avalon-MM register slave with waitrequest.
  Assumes a single clock sys_clk, synchronous active-high reset rst, and a
  pin input that is asynchronous to sys_clk.
*/
`include "epi_consts.svh"

module epi_core (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire epi_pkg::epi_bus_req_t bus_req,
  output      epi_pkg::epi_bus_rsp_t bus_rsp,
  input  wire logic                  req_pin,
  output      epi_pkg::epi_pull_t    pull,
  output      logic                  cpu_irq,
  output      logic                  sys_irq
);
  import epi_pkg::*;

  epi_state_t s_r;
  epi_state_t s_nxt;

  // ---------------------------------------------------------------
  // Combined next-state logic
  // ---------------------------------------------------------------
  logic                   pe;
  logic                   pol;
  logic                   asserted;
  logic                   edge_hit;
  logic                   event_hit;
  logic                   wr_ctrl;
  logic                   wr_stat;
  logic                   wr_mask;
  logic                   ack;
  logic [`EPI_STAT_W-1:0] new_ev;
  logic [7:0]             ctrl_view;

  always_comb begin
    s_nxt = s_r;
    pe    = s_r.ctrl[`EPI_BIT_PE];
    pol   = s_r.ctrl[`EPI_BIT_POL];

    // Pin synchroniser; the second stage and its delayed copy pin_prev are looked at
    s_nxt.pin_meta = req_pin;
    s_nxt.pin_sync = s_r.pin_meta;
    s_nxt.pin_prev = s_r.pin_sync;

    // Polarity-aware detection
    asserted  = (s_r.pin_sync == pol);
    edge_hit  = asserted && (s_r.pin_prev != pol);
    event_hit = pe && (edge_hit ||
                (s_r.ctrl[`EPI_BIT_MODE] && asserted));

    // Bus decode: one-cycle wait then answer
    wr_ctrl = 1'b0;
    wr_stat = 1'b0;
    wr_mask = 1'b0;
    ctrl_view = s_r.ctrl;
    ctrl_view[`EPI_BIT_FLAG] = s_r.ext_event_flag;
    ctrl_view[`EPI_BIT_ACK]  = 1'b0;
    case (s_r.bus_st)
      EPI_BUS_IDLE: begin
        if (bus_req.read || bus_req.write) begin
          s_nxt.bus_st   = EPI_BUS_DONE;
          s_nxt.readdata = 32'h0000_0000;
          if (bus_req.read) begin
            if (bus_req.address == `EPI_OFS_CTRL) begin
              s_nxt.readdata = {24'h00_0000, ctrl_view};
            end else if (bus_req.address == `EPI_OFS_INT_STAT) begin
              s_nxt.readdata = {30'h0000_0000, s_r.int_stat};
            end else if (bus_req.address == `EPI_OFS_INT_MASK) begin
              s_nxt.readdata = {30'h0000_0000, s_r.int_mask};
            end
          end else begin
            if (bus_req.address == `EPI_OFS_CTRL) begin
              wr_ctrl = 1'b1;
            end else if (bus_req.address == `EPI_OFS_INT_STAT) begin
              wr_stat = 1'b1;
            end else if (bus_req.address == `EPI_OFS_INT_MASK) begin
              wr_mask = 1'b1;
            end
          end
        end
      end
      EPI_BUS_DONE: begin
        s_nxt.bus_st = EPI_BUS_IDLE;
      end
      default: begin
        s_nxt.bus_st = EPI_BUS_IDLE;
      end
    endcase

    // Control bits; flag and acknowledge bits are not stored
    if (wr_ctrl) begin
      s_nxt.ctrl = bus_req.writedata[7:0] & `EPI_CTRL_WMASK;
    end
    ack = wr_ctrl && bus_req.writedata[`EPI_BIT_ACK];

    // Sticky event flag: set beats acknowledge
    if (event_hit) begin
      s_nxt.ext_event_flag = 1'b1;
    end else if (ack) begin
      s_nxt.ext_event_flag = 1'b0;
    end

    // System interrupt status: write one to clear, set wins
    new_ev = '0;
    new_ev[`EPI_STAT_EDGE]  = pe && edge_hit;
    new_ev[`EPI_STAT_LEVEL] = event_hit && !edge_hit;
    if (wr_stat) begin
      s_nxt.int_stat = s_r.int_stat & ~bus_req.writedata[`EPI_STAT_W-1:0];
    end
    s_nxt.int_stat = s_nxt.int_stat | new_ev;
    if (wr_mask) begin
      s_nxt.int_mask = bus_req.writedata[`EPI_STAT_W-1:0];
    end
    s_nxt.sys_irq = |(s_nxt.int_stat & s_nxt.int_mask);

    // CPU request follows the flag while enabled
    s_nxt.cpu_irq = s_nxt.ext_event_flag && s_nxt.ctrl[`EPI_BIT_IE];

    // Pull device direction follows polarity
    s_nxt.pull.pull_up_en   = s_nxt.ctrl[`EPI_BIT_PE] &&
                              !s_nxt.ctrl[`EPI_BIT_PDD] &&
                              !s_nxt.ctrl[`EPI_BIT_POL];
    s_nxt.pull.pull_down_en = s_nxt.ctrl[`EPI_BIT_PE] &&
                              !s_nxt.ctrl[`EPI_BIT_PDD] &&
                              s_nxt.ctrl[`EPI_BIT_POL];
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_r <= '{bus_st: EPI_BUS_IDLE, ctrl: `EPI_CTRL_RESET, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus_rsp.readdata    = s_r.readdata;
  assign bus_rsp.waitrequest = (s_r.bus_st == EPI_BUS_IDLE);
  assign pull                = s_r.pull;
  assign cpu_irq             = s_r.cpu_irq;
  assign sys_irq             = s_r.sys_irq;

endmodule // epi_core

// *** inc/epi_consts.svh ***
/*
  Constants of the external pin interrupt block: register offsets, field
  positions and reset values.
  Assumes inclusion by the package and the design file under its bare name.
*/
`ifndef EPI_CONSTS_SVH
`define EPI_CONSTS_SVH

`define EPI_ADDR_W         4
`define EPI_OFS_CTRL       4'h0
`define EPI_OFS_INT_STAT   4'h4
`define EPI_OFS_INT_MASK   4'h8
`define EPI_BIT_MODE       0
`define EPI_BIT_IE         1
`define EPI_BIT_ACK        2
`define EPI_BIT_FLAG       3
`define EPI_BIT_PE         4
`define EPI_BIT_POL        5
`define EPI_BIT_PDD        6
`define EPI_CTRL_RESET     8'h00
`define EPI_CTRL_WMASK     8'h73
`define EPI_STAT_W         2
`define EPI_STAT_EDGE      0
`define EPI_STAT_LEVEL     1

`endif

// *** inc/epi_pkg.sv ***
/*
  Types of the external pin interrupt block.
  Assumes epi_consts.svh on the include path.
*/
`include "epi_consts.svh"

package epi_pkg;

  typedef struct packed {
    logic [`EPI_ADDR_W-1:0] address;
    logic                   read;
    logic                   write;
    logic [31:0]            writedata;
  } epi_bus_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } epi_bus_rsp_t;

  typedef struct packed {
    logic pull_up_en;
    logic pull_down_en;
  } epi_pull_t;

  typedef enum logic {
    EPI_BUS_IDLE,
    EPI_BUS_DONE
  } epi_bus_st_t;

  typedef struct packed {
    epi_bus_st_t             bus_st;
    logic [31:0]             readdata;
    logic [7:0]              ctrl;
    logic                    ext_event_flag;
    logic [`EPI_STAT_W-1:0]  int_stat;
    logic [`EPI_STAT_W-1:0]  int_mask;
    logic                    pin_meta;
    logic                    pin_sync;
    logic                    pin_prev;
    logic                    cpu_irq;
    logic                    sys_irq;
    epi_pull_t               pull;
  } epi_state_t;

endpackage : epi_pkg

// *** tb/epi_properties.sv ***
/* Port checker for epi_core, bound onto every instance.
   Assumes epi_consts.svh on the include path and one clock domain. */
`include "epi_consts.svh"
module epi_properties (
  input wire logic                  sys_clk,
  input wire logic                  rst,
  input wire epi_pkg::epi_bus_req_t bus_req,
  input wire epi_pkg::epi_bus_rsp_t bus_rsp,
  input wire logic                  req_pin,
  input wire epi_pkg::epi_pull_t    pull,
  input wire logic                  cpu_irq
);
  import epi_pkg::*;
  logic [6:0] sh_r;
  logic       done;
  assign done = !bus_rsp.waitrequest;
  // Shadow of the control bits as software last wrote them
  always_ff @(posedge sys_clk) begin
    if (rst) sh_r <= 7'h00;
    else if (bus_req.write && done && bus_req.address == `EPI_OFS_CTRL)
      sh_r <= bus_req.writedata[6:0];
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_req; $rose(bus_req.read || bus_req.write); endsequence
  sequence s_ack; done ##1 bus_rsp.waitrequest; endsequence
  property p_answer; s_req |=> done; endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");
  property p_one; done |-> s_ack; endproperty
  a_one: assert property (p_one) else $error("waitrequest low too long");
  property p_rdzero; bus_req.read && done && bus_req.address == `EPI_OFS_CTRL
    |-> bus_rsp.readdata[2] == 1'b0 && bus_rsp.readdata[7] == 1'b0; endproperty
  a_rdzero: assert property (p_rdzero) else $error("ack bit reads back");
  property p_unmapped; bus_req.read && done && bus_req.address != `EPI_OFS_CTRL
    && bus_req.address != `EPI_OFS_INT_STAT && bus_req.address != `EPI_OFS_INT_MASK
    |-> bus_rsp.readdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_excl; !(pull.pull_up_en && pull.pull_down_en); endproperty
  a_excl: assert property (p_excl) else $error("both pulls on");
  // The design takes a write one edge before the shadow does; skip the answer cycle
  property p_pull; $stable(sh_r) && !done |-> pull == {sh_r[4] & !sh_r[5] & !sh_r[6],
    sh_r[4] & sh_r[5] & !sh_r[6]}; endproperty
  a_pull: assert property (p_pull) else $error("pull device wrong");
  property p_irq_off; $stable(sh_r) && !done && !sh_r[1] |-> !cpu_irq; endproperty
  a_irq_off: assert property (p_irq_off) else $error("request while disabled");
  property p_pin; (sh_r[5] ? $rose(req_pin) : $fell(req_pin)) && sh_r[4] && sh_r[1]
    && !sh_r[0] && $stable(sh_r) |-> ##[1:5] cpu_irq; endproperty
  a_pin: assert property (p_pin) else $error("pin edge missed");
endmodule // epi_properties
bind epi_core epi_properties u_epi_properties (.sys_clk(sys_clk), .rst(rst),
  .bus_req(bus_req), .bus_rsp(bus_rsp), .req_pin(req_pin), .pull(pull), .cpu_irq(cpu_irq));

// *** tb/epi_source.sv ***
/* External source on the request pin.
   Assumes pull enables from epi_core and a bench that drives or releases. */
module epi_source (
  input  wire logic               sys_clk,
  input  wire logic               drive_en,
  input  wire logic               drive_val,
  input  wire epi_pkg::epi_pull_t pull,
  output      logic               req_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  import epi_pkg::*;
  logic last_r = 1'b0;
  always @(posedge sys_clk) if (drive_en) last_r <= drive_val;
  // Released pin rests at the pull level, else shows the inverse of the last drive
  assign req_pin = drive_en ? drive_val : pull.pull_up_en ? 1'b1 :
                   pull.pull_down_en ? 1'b0 : ~last_r;
endmodule // epi_source

// *** tb/testbench.sv ***
/* Register-level tests of epi_core with a pin source.
   Assumes epi_pkg compiled and the checker bound. */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import epi_pkg::*;
  logic         sys_clk = 1'b0, rst = 1'b1, d_en = 1'b0, d_val = 1'b0;
  logic         cpu_irq, sys_irq, req_pin;
  logic [31:0]  q;
  epi_bus_req_t breq = '0;
  epi_bus_rsp_t brsp;
  epi_pull_t    pull;
  int           n_mismatch = 0, n_compared = 0;
  always #2.5 sys_clk = ~sys_clk;
  epi_core i_epi_core (.sys_clk(sys_clk), .rst(rst), .bus_req(breq), .bus_rsp(brsp),
    .req_pin(req_pin), .pull(pull), .cpu_irq(cpu_irq), .sys_irq(sys_irq));
  epi_source i_epi_source (.sys_clk(sys_clk), .drive_en(d_en), .drive_val(d_val),
    .pull(pull), .req_pin(req_pin));
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i = 0;
    breq <= '{address: a, read: !w, write: w, writedata: d};
    do begin @(posedge sys_clk); i++; end while (brsp.waitrequest !== 1'b0 && i < 50);
    q = brsp.readdata;
    breq.read <= 1'b0;
    breq.write <= 1'b0;
    @(posedge sys_clk);
    if (i >= 50) n_mismatch++;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string s);
    bus(1'b0, a, 32'h0);
    chk(s, e, q);
  endtask
  task automatic pin(input logic v);
    d_en <= 1'b1;
    d_val <= v;
    repeat (6) @(posedge sys_clk);
  endtask
  task summarize;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #5us;
    n_mismatch++;
    summarize;
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(4'h0, 32'h00, "ctrl reset");
    rd(4'hC, 32'h00, "unmapped");
    $display("test reset done");
    bus(1'b1, 4'h0, 32'h12);
    chk("pull", 32'h2, pull);
    pin(1'b1);
    pin(1'b0);
    bus(1'b1, 4'h0, 32'h12);
    rd(4'h0, 32'h1A, "flag kept");
    chk("cpu_irq", 32'h1, cpu_irq);
    bus(1'b1, 4'h0, 32'h16);
    rd(4'h0, 32'h12, "ack");
    $display("test edge done");
    bus(1'b1, 4'h0, 32'h33);
    chk("pull", 32'h1, pull);
    pin(1'b1);
    bus(1'b1, 4'h0, 32'h37);
    rd(4'h0, 32'h3B, "level ack");
    d_en <= 1'b0;
    repeat (4) @(posedge sys_clk);
    bus(1'b1, 4'h0, 32'h37);
    rd(4'h0, 32'h33, "level clear");
    $display("test level done");
    bus(1'b1, 4'h0, 32'h02);
    pin(1'b1);
    pin(1'b0);
    rd(4'h0, 32'h02, "disabled");
    bus(1'b1, 4'h0, 32'h72);
    chk("pull", 32'h0, pull);
    bus(1'b1, 4'h0, 32'h02);
    $display("test enable done");
    bus(1'b1, 4'h8, 32'h1);
    chk("sys_irq", 32'h1, sys_irq);
    bus(1'b1, 4'h8, 32'h0);
    chk("sys_irq", 32'h0, sys_irq);
    rd(4'h4, 32'h3, "stat set");
    bus(1'b1, 4'h4, 32'h3);
    rd(4'h4, 32'h0, "stat clear");
    bus(1'b1, 4'h8, 32'h3);
    chk("sys_irq", 32'h0, sys_irq);
    $display("test stat done");
    summarize;
  end
endmodule // testbench
